// >>> src/acmp_pkg.sv
// package: constants and types shared by the analog comparator control logic
// assumes: one 40 MHz system clock, no register bus (control bits are plain ports)
package acmp_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned NUM_CMP = 2;
    localparam int unsigned SRC_W = 2;
    localparam int unsigned REF_TAP_W = 4;
    // positive-source select codes
    localparam logic [1:0] SRC_OWN_PIN = 2'h0;
    localparam logic [1:0] SRC_CMP0_POS = 2'h1;
    localparam logic [1:0] SRC_INT_REF = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    // reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [1:0] EN_RESET = 2'h0;
    localparam logic [3:0] REF_TAP_RESET = 4'h0;
    // interrupt sense modes
    typedef enum logic [1:0] {
        SENSE_LEVEL,
        SENSE_FALL,
        SENSE_RISE,
        SENSE_BOTH
    } sense_t;
endpackage

// >>> src/cmp_ctl_if.sv
// interface: per-comparator control and status bundle
// assumes: controls driven by the top module, status driven by the comparator channel
`timescale 1ns/1ps
interface cmp_ctl_if;
    logic [1:0] pos_sel;
    logic invert;
    logic [1:0] sense;
    logic irq_en;
    logic clr;
    logic result;
    logic raw_flag;
    logic masked_flag;
    logic pos_valid;
    modport top (output pos_sel, invert, sense, irq_en, clr,
                 input result, raw_flag, masked_flag, pos_valid);
    modport chan (input pos_sel, invert, sense, irq_en, clr,
                  output result, raw_flag, masked_flag, pos_valid);
endinterface

// >>> src/cmp_channel.sv
// comparator channel: synchronises one analog result and keeps its flags
// assumes: cmp_raw_i is the asynchronous analog comparator output
`timescale 1ns/1ps
module cmp_channel
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n,
    input wire logic ce_i,
    input wire logic cmp_raw_i,
    cmp_ctl_if.chan ctl
);
    logic sync1;
    logic sync2;
    logic prev;
    logic raw_flag;
    logic result;
    logic event_hit;
    logic pos_valid;
    logic [2:0] primed;

    // two-stage synchroniser, first stage read by second only
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            primed <= 3'h0;
        end else if (ce_i) begin
            sync1 <= cmp_raw_i;
            sync2 <= sync1;
            prev <= sync2;
            primed <= {primed[1:0], 1'b1};
        end
    end

    // edge or level sense chosen by software
    // edges wait until prev holds a real sample, else reset fakes a rising edge
    assign event_hit = (ctl.sense == 2'(SENSE_LEVEL)) ? sync2 :
                       !primed[2] ? 1'b0 :
                       (ctl.sense == 2'(SENSE_FALL)) ? (prev & ~sync2) :
                       (ctl.sense == 2'(SENSE_RISE)) ? (~prev & sync2) :
                       (prev ^ sync2);

    // sticky raw flag; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            raw_flag <= 1'b0;
            result <= 1'b0;
            pos_valid <= 1'b0;
        end else if (ce_i) begin
            raw_flag <= event_hit | (raw_flag & ~ctl.clr);
            result <= sync2 ^ ctl.invert;
            pos_valid <= (ctl.pos_sel != SRC_RESERVED);
        end
    end

    assign ctl.result = result;
    assign ctl.raw_flag = raw_flag;
    assign ctl.masked_flag = raw_flag & ctl.irq_en;
    assign ctl.pos_valid = pos_valid;
endmodule

// >>> src/analog_comparator_control.sv
// top: digital control of two analog comparators, plain control ports
// assumes: analog compare cells outside; they take the mux selects driven here
// Notes on behaviour
// - two independent comparators, pin or interrupt
// - result one when negative below positive
// - negative input always its own pin; here neg_mux_own_o is low until the first enabled edge after reset
// - positive sources: own, comparator 0 positive, reference
// - comparator 1 code 01 takes comparator 0 positive
// - comparator 1 code 10 takes internal reference
// - result feeds interrupt, optionally drives pin; the interrupt flag here is taken from sync2, before the invert
// - interrupt may trigger sample capture
// - each comparator has control and status
// - reference set by one dedicated control group
// - masked, raw and enable interrupt groups
// - comparator 1 shared pin has one role only; here oe rises one edge before the mux leaves the own pin
`timescale 1ns/1ps
module analog_comparator_control
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // analog compare cell outputs, asynchronous
    input wire logic cmp0_raw_i,
    input wire logic cmp1_raw_i,
    // comparator0_control_reg fields
    input wire logic [1:0] cmp0_pos_sel_i,
    input wire logic cmp0_invert_i,
    input wire logic [1:0] cmp0_sense_i,
    input wire logic cmp0_out_en_i,
    // comparator1_control_reg fields
    input wire logic [1:0] cmp1_pos_sel_i,
    input wire logic cmp1_invert_i,
    input wire logic [1:0] cmp1_sense_i,
    input wire logic cmp1_out_en_i,
    // reference_control_reg fields
    input wire logic ref_enable_i,
    input wire logic ref_range_i,
    input wire logic [3:0] ref_tap_i,
    // irq_enable_reg and clear strobes of masked_irq_status_reg
    input wire logic [1:0] irq_en_i,
    input wire logic [1:0] irq_clr_i,
    // comparator_status_reg values
    output logic [1:0] status_o,
    output logic [1:0] raw_irq_status_o,
    output logic [1:0] masked_irq_status_o,
    output logic irq_o,
    output logic capture_trigger_o,
    output logic [1:0] pos_valid_o,
    // analog mux selects: 0 own pin, 1 comparator 0 positive, 2 reference
    output logic [1:0] cmp0_pos_mux_o,
    output logic [1:0] cmp1_pos_mux_o,
    output logic neg_mux_own_o,
    // reference ladder controls
    output logic ref_enable_o,
    output logic ref_range_o,
    output logic [3:0] ref_tap_o,
    // output pins, each with output enable
    output logic cmp0_out_pin_o,
    output logic cmp0_out_pin_oe_o,
    output logic cmp1_shared_pin_o,
    output logic cmp1_shared_pin_oe_o
);
    logic rst_s1;
    logic rst_n;
    logic [1:0] sel_q [NUM_CMP];
    logic [1:0] next_mux [NUM_CMP];
    logic cmp1_pin_is_input;
    logic cmp1_drive_ok;
    logic [1:0] raw_vec;
    logic [1:0] masked_vec;
    logic [1:0] result_vec;
    logic [1:0] valid_vec;
    logic masked_prev;

    cmp_ctl_if ch0 ();
    cmp_ctl_if ch1 ();

    // reset released through two flops, asserted immediately
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // per-comparator control bundles
    assign ch0.pos_sel = cmp0_pos_sel_i;
    assign ch0.invert = cmp0_invert_i;
    assign ch0.sense = cmp0_sense_i;
    assign ch0.irq_en = irq_en_i[0];
    assign ch0.clr = irq_clr_i[0];
    assign ch1.pos_sel = cmp1_pos_sel_i;
    assign ch1.invert = cmp1_invert_i;
    assign ch1.sense = cmp1_sense_i;
    assign ch1.irq_en = irq_en_i[1];
    assign ch1.clr = irq_clr_i[1];

    // two independent channels, polarity inverted in the channel result flop
    cmp_channel u_ch0 (
        .clk_i(clk_i),
        .rst_n(rst_n),
        .ce_i(ce_i),
        .cmp_raw_i(cmp0_raw_i),
        .ctl(ch0.chan)
    );
    cmp_channel u_ch1 (
        .clk_i(clk_i),
        .rst_n(rst_n),
        .ce_i(ce_i),
        .cmp_raw_i(cmp1_raw_i),
        .ctl(ch1.chan)
    );

    // positive mux decode; reserved code on comparator 0 parks on own pin
    assign next_mux[0] = (cmp0_pos_sel_i == SRC_INT_REF) ? SRC_INT_REF
                         : SRC_OWN_PIN;
    assign next_mux[1] = (cmp1_pos_sel_i == SRC_CMP0_POS) ? SRC_CMP0_POS
                         : (cmp1_pos_sel_i == SRC_INT_REF) ? SRC_INT_REF
                         : SRC_OWN_PIN;

    // shared pin is the positive input only when own-pin source is picked
    assign cmp1_pin_is_input = (next_mux[1] == SRC_OWN_PIN);
    assign cmp1_drive_ok = cmp1_out_en_i & ~cmp1_pin_is_input;

    assign result_vec = {ch1.result, ch0.result};
    assign raw_vec = {ch1.raw_flag, ch0.raw_flag};
    assign masked_vec = {ch1.masked_flag, ch0.masked_flag};
    assign valid_vec = {ch1.pos_valid, ch0.pos_valid};

    // mux selects registered so glitches stay out of the analog path
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_q[0] <= SRC_RESET;
            sel_q[1] <= SRC_RESET;
        end else if (ce_i) begin
            sel_q[0] <= next_mux[0];
            sel_q[1] <= next_mux[1];
        end
    end

    // every output from a flop
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmp0_pos_mux_o <= SRC_RESET;
            cmp1_pos_mux_o <= SRC_RESET;
            neg_mux_own_o <= 1'b0;
            ref_enable_o <= 1'b0;
            ref_range_o <= 1'b0;
            ref_tap_o <= REF_TAP_RESET;
        end else if (ce_i) begin
            cmp0_pos_mux_o <= sel_q[0];
            cmp1_pos_mux_o <= sel_q[1];
            neg_mux_own_o <= 1'b1;
            ref_enable_o <= ref_enable_i;
            ref_range_o <= ref_range_i;
            ref_tap_o <= ref_tap_i;
        end
    end

    // status, interrupt and pin drive
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status_o <= EN_RESET;
            raw_irq_status_o <= EN_RESET;
            masked_irq_status_o <= EN_RESET;
            irq_o <= 1'b0;
            masked_prev <= 1'b0;
            capture_trigger_o <= 1'b0;
            pos_valid_o <= EN_RESET;
            cmp0_out_pin_o <= 1'b0;
            cmp0_out_pin_oe_o <= 1'b0;
            cmp1_shared_pin_o <= 1'b0;
            cmp1_shared_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            status_o <= result_vec;
            raw_irq_status_o <= raw_vec;
            masked_irq_status_o <= masked_vec;
            irq_o <= |masked_vec;
            masked_prev <= |masked_vec;
            capture_trigger_o <= (|masked_vec) & ~masked_prev;
            pos_valid_o <= valid_vec;
            cmp0_out_pin_o <= result_vec[0];
            cmp0_out_pin_oe_o <= cmp0_out_en_i;
            cmp1_shared_pin_o <= result_vec[1];
            cmp1_shared_pin_oe_o <= cmp1_drive_ok;
        end
    end
endmodule

// >>> bench/analog_front.sv
// partner: analog compare cells and pin voltages in front of the block
// assumes: volt_i is {ref, pos1, neg1, pos0, neg0}; bench avoids equal values
`timescale 1ns/1ps
module analog_front (
    input wire logic [1:0] mux0_i,
    input wire logic [1:0] mux1_i,
    input wire logic [4:0][7:0] volt_i,
    output logic raw0_o,
    output logic raw1_o
);
    logic [7:0] pos0;
    logic [7:0] pos1;
    // positive source follows the mux select, reserved falls to own pin
    assign pos0 = (mux0_i == 2'h2) ? volt_i[4] : volt_i[1];
    assign pos1 = (mux1_i == 2'h2) ? volt_i[4] :
        (mux1_i == 2'h1) ? volt_i[1] : volt_i[3];
    // negative side is always the own pin; pins read as analog levels only
    assign raw0_o = volt_i[0] < pos0;
    assign raw1_o = volt_i[2] < pos1;
endmodule

// >>> bench/acmp_props.sv
// checker: port timing of the comparator control block
// assumes: bound onto analog_comparator_control, one clock domain
`timescale 1ns/1ps
module acmp_props
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic cmp0_raw_i,
    input wire logic cmp0_invert_i,
    input wire logic [1:0] cmp0_pos_sel_i,
    input wire logic [1:0] cmp1_pos_sel_i,
    input wire logic [1:0] irq_en_i,
    input wire logic [1:0] status_o,
    input wire logic [1:0] raw_irq_status_o,
    input wire logic [1:0] masked_irq_status_o,
    input wire logic irq_o,
    input wire logic capture_trigger_o,
    input wire logic [1:0] cmp0_pos_mux_o,
    input wire logic [1:0] cmp1_pos_mux_o,
    input wire logic neg_mux_own_o,
    input wire logic cmp1_shared_pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // long enough after release for the two-flop reset copy
    sequence settled;
        nrst_i [*8];
    endsequence
    sequence run3;
        ce_i [*3];
    endsequence
    // sync pair, result flop and status flop: four enabled edges
    sequence steady_inv;
        ce_i && $stable(cmp0_invert_i);
    endsequence
    chk_neg_own: assert property (settled |-> neg_mux_own_o)
        else $error("negative mux left own pin");
    chk_mux0_sel: assert property (settled ##0 run3 |->
        cmp0_pos_mux_o == (($past(cmp0_pos_sel_i, 2) == 2'h2) ? 2'h2 : 2'h0))
        else $error("comparator 0 mux select wrong");
    chk_mux1_sel: assert property (settled ##0 run3 |->
        cmp1_pos_mux_o == (($past(cmp1_pos_sel_i, 2) == 2'h3) ? 2'h0 : $past(cmp1_pos_sel_i, 2)))
        else $error("comparator 1 mux select wrong");
    chk_shared_pin_role: assert property (settled ##0
        (ce_i && cmp1_pos_sel_i[0] == cmp1_pos_sel_i[1])[*6] |-> !cmp1_shared_pin_oe_o)
        else $error("shared pin driven while used as input");
    chk_status_sync: assert property (settled ##0 steady_inv[*5] |->
        status_o[0] == ($past(cmp0_raw_i, 4) ^ cmp0_invert_i))
        else $error("status not four edges behind result");
    chk_mask_gate: assert property (settled ##0
        (ce_i && $stable(raw_irq_status_o) && $stable(irq_en_i))[*2] |->
        masked_irq_status_o == (raw_irq_status_o & irq_en_i))
        else $error("masked flag not raw and enable");
    chk_irq_or: assert property (
        settled ##0 (ce_i && $stable(masked_irq_status_o))[*2] |->
        irq_o == (|masked_irq_status_o))
        else $error("interrupt not or of masked flags");
    // pulse rises with the interrupt and lasts one enabled edge
    chk_capture_pulse: assert property (
        settled ##0 ($rose(irq_o) && ce_i) |-> capture_trigger_o ##1 !capture_trigger_o)
        else $error("capture pulse missing or long");
endmodule
bind analog_comparator_control acmp_props acmp_props_inst (.*);

// >>> bench/analog_comparator_control_tb.sv
// bench: self-checking scenarios for the comparator control block
// assumes: analog_front stands in for the compare cells
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module analog_comparator_control_tb;
    import acmp_pkg::*;
    logic clk_i, nrst_i, ce_i, cmp0_raw_i, cmp1_raw_i, cmp0_invert_i, cmp1_invert_i;
    logic cmp0_out_en_i, cmp1_out_en_i, ref_enable_i, ref_range_i, irq_o;
    logic [1:0] cmp0_pos_sel_i, cmp1_pos_sel_i, cmp0_sense_i, cmp1_sense_i;
    logic [1:0] irq_en_i, irq_clr_i, status_o, raw_irq_status_o, masked_irq_status_o;
    logic [1:0] pos_valid_o, cmp0_pos_mux_o, cmp1_pos_mux_o;
    logic [3:0] ref_tap_i, ref_tap_o;
    logic capture_trigger_o, neg_mux_own_o, ref_enable_o, ref_range_o;
    logic cmp0_out_pin_o, cmp0_out_pin_oe_o, cmp1_shared_pin_o, cmp1_shared_pin_oe_o;
    logic [4:0][7:0] volt;
    int errors, checked;
    analog_comparator_control analog_comparator_control_inst (.*);
    analog_front analog_front_inst (.mux0_i(cmp0_pos_mux_o), .mux1_i(cmp1_pos_mux_o),
        .volt_i(volt), .raw0_o(cmp0_raw_i), .raw1_o(cmp1_raw_i));
    // 25 ns period
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    // inputs move 2 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic close_out();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // every select code on both comparators, reserved one included
    task automatic t_mux();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            cmp0_pos_sel_i = c;
            cmp1_pos_sel_i = c;
            step(8);
            `CHK(cmp0_pos_mux_o, ((c == 2'h2) ? 2'h2 : 2'h0))
            `CHK(cmp1_pos_mux_o, ((c == 2'h3) ? 2'h0 : c))
            `CHK(pos_valid_o, {2{c != 2'h3}})
            `CHK(status_o, {c == 2'h1, c != 2'h2})
            `CHK(neg_mux_own_o, 1'h1)
        end
    endtask
    // one-cycle clear strobe on the chosen flags
    task automatic clr_flags(input logic [1:0] m);
        irq_clr_i = m;
        step(1);
        irq_clr_i = 2'h0;
    endtask
    // rising edge raises flag, mask gates it, clear drops it
    task automatic t_irq();
        int n;
        n = 0;
        cmp0_pos_sel_i = 2'h0;
        cmp0_sense_i = 2'h2;
        volt[0] = 8'h96;
        step(8);
        irq_clr_i = 2'h3;
        step(1);
        irq_clr_i = 2'h0;
        irq_en_i = 2'h1;
        step(3);
        `CHK(raw_irq_status_o, 2'h0)
        volt[0] = 8'h50;
        for (int k = 0; k < 12; k++) begin
            step(1);
            n += int'(capture_trigger_o === 1'h1);
        end
        `CHK(n, 1)
        `CHK({irq_o, masked_irq_status_o, raw_irq_status_o}, 5'h15)
        irq_en_i = 2'h0;
        step(4);
        `CHK({irq_o, masked_irq_status_o, raw_irq_status_o}, 5'h01)
        irq_clr_i = 2'h1;
        step(1);
        irq_clr_i = 2'h0;
        step(3);
        `CHK(raw_irq_status_o, 2'h0)
    endtask
    // shared pin only drives when comparator 1 takes another source
    task automatic t_pin();
        cmp0_out_en_i = 1'h1;
        cmp1_out_en_i = 1'h1;
        cmp0_invert_i = 1'h1;
        cmp1_pos_sel_i = 2'h0;
        step(8);
        `CHK({cmp0_out_pin_oe_o, cmp0_out_pin_o, cmp1_shared_pin_oe_o}, 3'h4)
        cmp1_pos_sel_i = 2'h1;
        step(8);
        `CHK({cmp1_shared_pin_oe_o, cmp1_shared_pin_o, status_o}, 4'he)
        ref_enable_i = 1'h1;
        ref_range_i = 1'h1;
        ref_tap_i = 4'ha;
        step(2);
        `CHK({ref_enable_o, ref_range_o, ref_tap_o}, 6'h3a)
    endtask
    // falling, both and rising sense on comparator 0; a level event beats a clear
    task automatic t_sense();
        cmp0_sense_i = 2'h1;
        volt[0] = 8'h96;
        step(6);
        `CHK(raw_irq_status_o[0], 1'h1)
        clr_flags(2'h1);
        volt[0] = 8'h50;
        step(6);
        `CHK(raw_irq_status_o[0], 1'h0)
        cmp0_sense_i = 2'h3;
        volt[0] = 8'h96;
        step(6);
        `CHK(raw_irq_status_o[0], 1'h1)
        clr_flags(2'h1);
        volt[0] = 8'h50;
        step(6);
        `CHK(raw_irq_status_o[0], 1'h1)
        clr_flags(2'h1);
        cmp0_sense_i = 2'h2;
        volt[0] = 8'h96;
        step(6);
        `CHK(raw_irq_status_o[0], 1'h0)
        clr_flags(2'h2);
        step(3);
        `CHK(raw_irq_status_o[1], 1'h1)
    endtask
    // comparator 1 inverted with its interrupt, then a clock-enable freeze
    task automatic t_ch1();
        cmp1_invert_i = 1'h1;
        irq_en_i = 2'h2;
        step(6);
        `CHK({status_o[1], masked_irq_status_o, irq_o}, 4'h5)
        `CHK({cmp1_shared_pin_oe_o, cmp1_shared_pin_o}, 2'h2)
        `CHK({cmp0_out_pin_oe_o, cmp0_out_pin_o}, 2'h3)
        ce_i = 1'h0;
        volt[2] = 8'hff;
        ref_tap_i = 4'h5;
        step(8);
        `CHK({status_o[1], ref_tap_o}, 5'h0a)
        ce_i = 1'h1;
        step(6);
        `CHK({status_o[1], ref_tap_o}, 5'h15)
    endtask
    // reset in mid-run clears outputs; two edges pass after release before they move
    task automatic t_rst();
        nrst_i = 1'h0;
        step(2);
        `CHK({status_o, raw_irq_status_o, irq_o, neg_mux_own_o}, 6'h00)
        nrst_i = 1'h1;
        step(1);
        `CHK(neg_mux_own_o, 1'h0)
        step(2);
        `CHK(neg_mux_own_o, 1'h1)
    endtask
    initial begin
        errors = 0;
        checked = 0;
        nrst_i = 1'h0;
        ce_i = 1'h1;
        {cmp0_invert_i, cmp1_invert_i, cmp0_out_en_i, cmp1_out_en_i} = 4'h0;
        {ref_enable_i, ref_range_i, ref_tap_i, irq_en_i, irq_clr_i} = 10'h000;
        {cmp0_pos_sel_i, cmp1_pos_sel_i, cmp0_sense_i, cmp1_sense_i} = 8'h00;
        volt = {8'h3c, 8'h0a, 8'h5a, 8'h64, 8'h50};
        step(20);
        nrst_i = 1'h1;
        step(4);
        t_mux();
        t_irq();
        t_pin();
        t_sense();
        t_ch1();
        t_rst();
        close_out();
    end
    // scenarios need about 170 cycles; cut off far beyond that
    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule
